// *** logic/orps_pkg.sv ***
/*
 Constants for the optical receive phase sequencer: clock figures, register
 offsets, field positions, reset values and the converter state encoding.
 Assumes a 50 MHz system clock and a plain register port with 6-bit addresses.
*/
package orps_pkg;
   localparam int CLK_MHZ = 50;
   localparam int XTAL_MHZ = 8;
   localparam int WORK_MHZ = XTAL_MHZ / 2;
   localparam logic [5:0] ACC_MOD = 6'(CLK_MHZ);
   localparam logic [5:0] ACC_STEP = 6'(XTAL_MHZ);
   localparam int SAMPLE_MIN_US = 50;
   localparam logic [7:0] SAMPLE_MIN_TICKS = 8'(SAMPLE_MIN_US * WORK_MHZ);

   localparam logic [5:0] OFS_CTRL = 6'h00;
   localparam logic [5:0] OFS_PERIOD = 6'h01;
   localparam logic [5:0] OFS_SAMP_BASE = 6'h02;
   localparam logic [5:0] OFS_CONV_BASE = 6'h0a;
   localparam logic [5:0] OFS_GAIN = 6'h12;
   localparam logic [5:0] OFS_RF = 6'h13;
   localparam logic [5:0] OFS_CF = 6'h14;
   localparam logic [5:0] OFS_DAC = 6'h15;
   localparam logic [5:0] OFS_STATUS = 6'h16;
   localparam logic [5:0] OFS_COUNT = 6'h17;
   localparam logic [5:0] OFS_RES_BASE = 6'h18;
   localparam logic [5:0] WIN_REGS = 6'h08;
   localparam logic [5:0] RES_REGS = 6'h06;

   localparam int CTRL_EN_BIT = 0;
   localparam int ST_SAMP = 0;
   localparam int ST_CONV = 4;
   localparam int ST_HELD = 8;
   localparam int ST_BUSY = 12;
   localparam int ST_CH = 13;
   localparam int ST_COLLIDE = 16;
   localparam int ST_OVERRUN = 17;

   localparam logic [15:0] PERIOD_RST = 16'h1f3f;
   localparam logic [15:0] WIN_RST = 16'h0000;
   localparam logic [2:0] GAIN_RST = 3'h0;
   localparam logic [2:0] RF_RST = 3'h0;
   localparam logic [5:0] CF_RST = 6'h00;
   localparam logic [3:0] DAC_RST = 4'h0;
   localparam logic [2:0] GAIN_MAX = 3'h4;
   localparam logic [2:0] RF_MAX = 3'h6;
   localparam logic [3:0] DAC_MAX = 4'ha;

   typedef enum logic [1:0] {
      CONV_IDLE = 2'b01,
      CONV_BUSY = 2'b10
   } orps_conv_t;
endpackage

// *** logic/orps_top.sv ***
/*
 Receive phase sequencer: work-clock divider, period counter, four sample
 windows, four staggered convert windows on one shared converter, result and
 ambient-difference store, a two-entry output stream buffer, register port.
 Assumes all inputs synchronous to clk and an external converter whose code
 on adcCode is valid when a convert window ends.
*/
// Behaviour
// - One shared 22-bit converter handles the four held samples strictly one at a time.
// - Each conversion lasts at most a quarter period and yields exactly one code.
// - A channel's conversion may start only after its sample window has ended.
// - Four result streams, each refreshed once per period.
// - Emitter minus ambient differences for both emitters are produced each period.
// - Sample windows programmable per channel, never shorter than 50 us.
// - Ambient cancellation setting selects one of eleven settings, 0 to 10 in 1 uA steps, via registers.
// - Second-stage gain offers exactly five settings.
// - Feedback resistor offers seven settings.
// - Feedback capacitors form a six-bit enable mask.
// - Ambient sample phase captures amplifier output during emitter off-time.
// - Convert phase routes the held sample to the converter; code taken at its end.
// - Working clock is the 8 MHz crystal rate halved to 4 MHz.
// - One 16-bit counter on the working clock wraps to zero at the period value.
`timescale 1ns/100ps
module orps_top import orps_pkg::*; #(
   parameter int DATA_W = 22
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [5:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   input wire logic [DATA_W-1:0] adcCode,
   output logic [1:0] adcRoute,
   output logic adcBusy,
   output logic emitterBSamplePhase,
   output logic emitterASamplePhase,
   output logic ambientBSamplePhase,
   output logic ambientASamplePhase,
   output logic emitterBConvertPhase,
   output logic emitterAConvertPhase,
   output logic ambientBConvertPhase,
   output logic ambientAConvertPhase,
   output logic [2:0] gainSel,
   output logic [2:0] feedbackRSel,
   output logic [5:0] feedbackCMask,
   output logic [3:0] ambientDac,
   output logic workTick,
   output logic [DATA_W+3:0] outData,
   output logic outValid,
   input wire logic outReady
);
   localparam int WORD_W = DATA_W + 4;

   if (DATA_W < 8 || DATA_W > 30) begin : g_bad_width
      $error("DATA_W must lie between 8 and 30");
   end

   // Channel index: 0 emitter B, 1 emitter A, 2 ambient B, 3 ambient A
   typedef struct packed {
      logic [5:0] acc;
      logic half;
      logic tick;
      logic en;
      logic [15:0] period;
      logic [15:0] cnt;
      logic [3:0][15:0] sStart;
      logic [3:0][15:0] sEnd;
      logic [3:0][15:0] cStart;
      logic [3:0][15:0] cEnd;
      logic [2:0] gain;
      logic [2:0] rf;
      logic [5:0] cf;
      logic [3:0] dac;
      logic [3:0] samp;
      logic [3:0] sHit;
      logic [3:0][7:0] sLen;
      logic [3:0] cWin;
      logic [3:0] cHit;
      logic [3:0] held;
      orps_conv_t conv;
      logic [1:0] ch;
      logic [15:0] cLen;
      logic [3:0] cPh;
      logic [3:0][DATA_W-1:0] res;
      logic [1:0][DATA_W:0] diff;
      logic [5:0] pend;
      logic overrun;
      logic collide;
      logic [WORD_W-1:0] b0;
      logic [WORD_W-1:0] b1;
      logic v0;
      logic v1;
      logic [31:0] rdata;
   } orps_state_t;

   orps_state_t s;
   orps_state_t next_s;

   logic [15:0] quarter;
   logic [5:0] winOff;
   logic [5:0] convOff;
   logic [5:0] resOff;
   logic [31:0] readVal;
   logic found;
   logic [1:0] pick;
   logic [DATA_W:0] code;
   logic [2:0] tag;
   logic [DATA_W:0] value;
   logic pop;
   logic push;

   // Ticks per period are period+1, so a quarter is that over four
   assign quarter = 16'((17'(s.period) + 17'h00001) >> 2);
   assign winOff = regAddr - OFS_SAMP_BASE;
   assign convOff = regAddr - OFS_CONV_BASE;
   assign resOff = regAddr - OFS_RES_BASE;
   assign code = {adcCode[DATA_W-1], adcCode};

   always_comb begin
      readVal = 32'h00000000;
      if (regAddr == OFS_CTRL) begin
         readVal[CTRL_EN_BIT] = s.en;
      end else if (regAddr == OFS_PERIOD) begin
         readVal[15:0] = s.period;
      end else if (winOff < WIN_REGS) begin
         readVal[15:0] = winOff[0] ? s.sEnd[winOff[2:1]] : s.sStart[winOff[2:1]];
      end else if (convOff < WIN_REGS) begin
         readVal[15:0] = convOff[0] ? s.cEnd[convOff[2:1]] : s.cStart[convOff[2:1]];
      end else if (regAddr == OFS_GAIN) begin
         readVal[2:0] = s.gain;
      end else if (regAddr == OFS_RF) begin
         readVal[2:0] = s.rf;
      end else if (regAddr == OFS_CF) begin
         readVal[5:0] = s.cf;
      end else if (regAddr == OFS_DAC) begin
         readVal[3:0] = s.dac;
      end else if (regAddr == OFS_STATUS) begin
         readVal[ST_SAMP +: 4] = s.samp;
         readVal[ST_CONV +: 4] = s.cPh;
         readVal[ST_HELD +: 4] = s.held;
         readVal[ST_BUSY] = (s.conv == CONV_BUSY);
         readVal[ST_CH +: 2] = s.ch;
         readVal[ST_COLLIDE] = s.collide;
         readVal[ST_OVERRUN] = s.overrun;
      end else if (regAddr == OFS_COUNT) begin
         readVal[15:0] = s.cnt;
      end else if (resOff < RES_REGS) begin
         if (resOff < 6'h04) begin
            readVal = 32'(signed'(s.res[resOff[1:0]]));
         end else begin
            readVal = 32'(signed'(s.diff[resOff[0]]));
         end
      end
   end

   always_comb begin
      next_s = s;
      found = 1'b0;
      pick = 2'h0;
      tag = 3'h0;
      value = '0;
      pop = 1'b0;
      push = 1'b0;
      next_s.rdata = regRd ? readVal : 32'h00000000;

      // Register writes come first so that hardware sets below win over clears
      if (regWr) begin
         if (regAddr == OFS_CTRL) begin
            next_s.en = regWdata[CTRL_EN_BIT];
         end else if (regAddr == OFS_PERIOD) begin
            next_s.period = regWdata[15:0];
         end else if (winOff < WIN_REGS) begin
            if (winOff[0]) begin
               next_s.sEnd[winOff[2:1]] = regWdata[15:0];
            end else begin
               next_s.sStart[winOff[2:1]] = regWdata[15:0];
            end
         end else if (convOff < WIN_REGS) begin
            if (convOff[0]) begin
               next_s.cEnd[convOff[2:1]] = regWdata[15:0];
            end else begin
               next_s.cStart[convOff[2:1]] = regWdata[15:0];
            end
         end else if (regAddr == OFS_GAIN) begin
            // Codes beyond the last setting are ignored
            if (regWdata[2:0] <= GAIN_MAX && regWdata[31:3] == '0) begin
               next_s.gain = regWdata[2:0];
            end
         end else if (regAddr == OFS_RF) begin
            if (regWdata[2:0] <= RF_MAX && regWdata[31:3] == '0) begin
               next_s.rf = regWdata[2:0];
            end
         end else if (regAddr == OFS_CF) begin
            next_s.cf = regWdata[5:0];
         end else if (regAddr == OFS_DAC) begin
            if (regWdata[3:0] <= DAC_MAX && regWdata[31:4] == '0) begin
               next_s.dac = regWdata[3:0];
            end
         end else if (regAddr == OFS_STATUS) begin
            next_s.collide = s.collide & ~regWdata[ST_COLLIDE];
            next_s.overrun = s.overrun & ~regWdata[ST_OVERRUN];
         end
      end

      // Fractional divider makes the 8 MHz rate, then halves it
      next_s.tick = 1'b0;
      if (s.acc + ACC_STEP >= ACC_MOD) begin
         next_s.acc = s.acc + ACC_STEP - ACC_MOD;
         next_s.half = ~s.half;
         next_s.tick = s.half;
      end else begin
         next_s.acc = s.acc + ACC_STEP;
      end

      if (!s.en) begin
         next_s.cnt = 16'h0000;
         next_s.samp = 4'h0;
         next_s.sHit = 4'h0;
         next_s.cWin = 4'h0;
         next_s.cHit = 4'h0;
         next_s.held = 4'h0;
         next_s.conv = CONV_IDLE;
      end else if (s.tick) begin
         next_s.cnt = (s.cnt == s.period) ? 16'h0000 : s.cnt + 16'h0001;
         for (int i = 0; i < 4; i++) begin
            // A window whose end comes early is stretched to the least length
            if (s.cnt == s.sStart[i]) begin
               next_s.samp[i] = 1'b1;
               next_s.sLen[i] = 8'h00;
               next_s.sHit[i] = (s.sStart[i] == s.sEnd[i]);
            end else if (s.samp[i]) begin
               if (s.sLen[i] != 8'hff) begin
                  next_s.sLen[i] = s.sLen[i] + 8'h01;
               end
               if (s.sHit[i] && s.sLen[i] >= SAMPLE_MIN_TICKS - 8'h01) begin
                  next_s.samp[i] = 1'b0;
                  next_s.sHit[i] = 1'b0;
                  next_s.held[i] = 1'b1;
               end else if (s.cnt == s.sEnd[i]) begin
                  next_s.sHit[i] = 1'b1;
               end
            end
            if (s.cnt == s.cStart[i]) begin
               next_s.cWin[i] = 1'b1;
               next_s.cHit[i] = (s.cStart[i] == s.cEnd[i]);
            end else if (s.cWin[i]) begin
               if (s.cHit[i]) begin
                  next_s.cWin[i] = 1'b0;
                  next_s.cHit[i] = 1'b0;
               end else if (s.cnt == s.cEnd[i]) begin
                  next_s.cHit[i] = 1'b1;
               end
            end
         end

         case (s.conv)
            CONV_IDLE: begin
               // Lowest channel wins; a window without a held sample is skipped
               for (int i = 3; i >= 0; i--) begin
                  if (s.cWin[i] && s.held[i]) begin
                     found = 1'b1;
                     pick = 2'(i);
                  end
               end
               if (found) begin
                  next_s.conv = CONV_BUSY;
                  next_s.ch = pick;
                  next_s.cLen = 16'h0000;
               end
            end
            CONV_BUSY: begin
               next_s.cLen = s.cLen + 16'h0001;
               if ((s.cWin & ~(4'h1 << s.ch)) != 4'h0) begin
                  next_s.collide = 1'b1;
               end
               // Window end or quarter-period cap closes the conversion
               if (!s.cWin[s.ch] || s.cLen + 16'h0001 >= quarter) begin
                  next_s.conv = CONV_IDLE;
                  next_s.res[s.ch] = adcCode;
                  next_s.held[s.ch] = 1'b0;
                  next_s.pend[s.ch] = 1'b1;
                  if (s.pend[s.ch]) begin
                     next_s.overrun = 1'b1;
                  end
                  if (s.ch[1]) begin
                     next_s.diff[s.ch[0]] = {s.res[s.ch[0]][DATA_W-1], s.res[s.ch[0]]}
                        - code;
                     next_s.pend[3'h4 + {2'h0, s.ch[0]}] = 1'b1;
                     if (s.pend[3'h4 + {2'h0, s.ch[0]}]) begin
                        next_s.overrun = 1'b1;
                     end
                  end
               end
            end
            default: begin
               next_s.conv = CONV_IDLE;
            end
         endcase
      end
      next_s.cPh = (next_s.conv == CONV_BUSY) ? (4'h1 << next_s.ch) : 4'h0;

      // Lowest-tagged pending result enters the buffer only when a slot is free
      for (int k = 5; k >= 0; k--) begin
         if (s.pend[k]) begin
            tag = 3'(k);
         end
      end
      if (tag < 3'h4) begin
         value = {s.res[tag[1:0]][DATA_W-1], s.res[tag[1:0]]};
      end else begin
         value = s.diff[tag[0]];
      end
      pop = s.v0 & outReady;
      push = (s.pend != 6'h00) && (!s.v1 || pop);
      if (pop) begin
         next_s.b0 = s.b1;
         next_s.v0 = s.v1;
         next_s.v1 = 1'b0;
      end
      if (push) begin
         next_s.pend[tag] = next_s.pend[tag] & ~(s.pend[tag] & ~(s.conv == CONV_BUSY &&
            next_s.conv == CONV_IDLE && (tag == {1'b0, s.ch} ||
            (s.ch[1] && tag == 3'h4 + {2'h0, s.ch[0]}))));
         if (!next_s.v0) begin
            next_s.b0 = {tag, value};
            next_s.v0 = 1'b1;
         end else begin
            next_s.b1 = {tag, value};
            next_s.v1 = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
         s.period <= PERIOD_RST;
         s.sStart <= {4{WIN_RST}};
         s.sEnd <= {4{WIN_RST}};
         s.cStart <= {4{WIN_RST}};
         s.cEnd <= {4{WIN_RST}};
         s.gain <= GAIN_RST;
         s.rf <= RF_RST;
         s.cf <= CF_RST;
         s.dac <= DAC_RST;
         s.conv <= CONV_IDLE;
      end else begin
         s <= next_s;
      end
   end

   assign regRdata = s.rdata;
   assign adcRoute = s.ch;
   assign adcBusy = s.conv[1]; // Busy code bit of the one-hot state
   assign emitterBSamplePhase = s.samp[0];
   assign emitterASamplePhase = s.samp[1];
   assign ambientBSamplePhase = s.samp[2];
   assign ambientASamplePhase = s.samp[3];
   assign emitterBConvertPhase = s.cPh[0];
   assign emitterAConvertPhase = s.cPh[1];
   assign ambientBConvertPhase = s.cPh[2];
   assign ambientAConvertPhase = s.cPh[3];
   assign gainSel = s.gain;
   assign feedbackRSel = s.rf;
   assign feedbackCMask = s.cf;
   assign ambientDac = s.dac;
   assign workTick = s.tick;
   assign outData = s.b0;
   assign outValid = s.v0;
endmodule

// *** tb/orps_top_chk.sv ***
/*
 Port checker for orps_top: phase exclusivity, routing, sample length,
 stream holding and legal setting ranges.
 Assumes the package is compiled first; bound to orps_top below.
*/
`timescale 1ns/100ps
module orps_top_chk import orps_pkg::*; #(
   parameter int DATA_W = 22
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic regRd,
   input wire logic [31:0] regRdata,
   input wire logic [1:0] adcRoute,
   input wire logic adcBusy,
   input wire logic emitterBSamplePhase,
   input wire logic emitterASamplePhase,
   input wire logic ambientBSamplePhase,
   input wire logic ambientASamplePhase,
   input wire logic emitterBConvertPhase,
   input wire logic emitterAConvertPhase,
   input wire logic ambientBConvertPhase,
   input wire logic ambientAConvertPhase,
   input wire logic [2:0] gainSel,
   input wire logic [2:0] feedbackRSel,
   input wire logic [3:0] ambientDac,
   input wire logic workTick,
   input wire logic [DATA_W+3:0] outData,
   input wire logic outValid,
   input wire logic outReady
);
   logic [15:0] sampLen;
   logic [3:0] convVec;
   assign convVec = {ambientAConvertPhase, ambientBConvertPhase, emitterAConvertPhase,
                     emitterBConvertPhase};
   // Length in work ticks of the current emitter B sample window
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sampLen <= 16'h0;
      end else if (!emitterBSamplePhase) begin
         sampLen <= 16'h0;
      end else if (workTick) begin
         sampLen <= sampLen + 16'h1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   chk_conv_single: assert property ($onehot0(convVec))
      else $error("two convert phases at once");
   chk_busy_or: assert property (adcBusy == (|convVec))
      else $error("busy differs from convert phases");
   chk_route_held: assert property (adcBusy |-> convVec[adcRoute])
      else $error("converter routed to wrong channel");
   chk_emb_staggered: assert property ($rose(emitterBConvertPhase) |-> !emitterBSamplePhase)
      else $error("emitter B converts while sampling");
   chk_ambb_staggered: assert property ($rose(ambientBConvertPhase) |-> !ambientBSamplePhase)
      else $error("ambient B converts while sampling");
   chk_ema_staggered: assert property ($rose(emitterAConvertPhase) |-> !emitterASamplePhase)
      else $error("emitter A converts while sampling");
   chk_amba_staggered: assert property ($rose(ambientAConvertPhase) |-> !ambientASamplePhase)
      else $error("ambient A converts while sampling");
   chk_samp_min: assert property ($fell(emitterBSamplePhase) |->
      sampLen >= 16'(SAMPLE_MIN_TICKS) - 16'h1)
      else $error("sample window too short");
   chk_read_idle: assert property (!$past(regRd) |-> regRdata == 32'h0)
      else $error("read data outside its cycle");
   chk_gain_legal: assert property (gainSel <= GAIN_MAX)
      else $error("gain setting out of range");
   chk_rf_legal: assert property (feedbackRSel <= RF_MAX)
      else $error("resistor setting out of range");
   chk_dac_legal: assert property (ambientDac <= DAC_MAX)
      else $error("cancellation setting out of range");
   chk_stream_hold: assert property (outValid && !outReady |=> outValid && $stable(outData))
      else $error("stream word dropped while stalled");
   chk_tick_gap: assert property (workTick |=> !workTick [*8])
      else $error("work tick too fast");
endmodule
bind orps_top orps_top_chk #(.DATA_W(DATA_W)) u_chk (.clk(clk), .rst_n(rst_n),
   .regRd(regRd), .regRdata(regRdata), .adcRoute(adcRoute), .adcBusy(adcBusy),
   .emitterBSamplePhase(emitterBSamplePhase), .emitterASamplePhase(emitterASamplePhase),
   .ambientBSamplePhase(ambientBSamplePhase), .ambientASamplePhase(ambientASamplePhase),
   .emitterBConvertPhase(emitterBConvertPhase), .emitterAConvertPhase(emitterAConvertPhase),
   .ambientBConvertPhase(ambientBConvertPhase), .ambientAConvertPhase(ambientAConvertPhase),
   .gainSel(gainSel), .feedbackRSel(feedbackRSel), .ambientDac(ambientDac),
   .workTick(workTick), .outData(outData), .outValid(outValid), .outReady(outReady));

// *** tb/orps_far_end.sv ***
/*
 Far-side model: a converter that answers with a fixed code per routed
 channel, and a stream sink that is slow and can be stalled.
 Assumes codeSet and stall are driven by the bench.
*/
`timescale 1ns/100ps
module orps_far_end #(
   parameter int DATA_W = 22
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [1:0] adcRoute,
   input wire logic adcBusy,
   input wire logic stall,
   input wire logic [3:0][DATA_W-1:0] codeSet,
   output logic [DATA_W-1:0] adcCode,
   output logic outReady
);
   logic [DATA_W-1:0] junk;
   logic [1:0] slow;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         junk <= '0;
         slow <= 2'h0;
      end else begin
         junk <= ~junk;
         slow <= slow + 2'h1;
      end
   end
   // Outside a conversion the code lines carry a changing pattern, never a held value
   assign adcCode = adcBusy ? codeSet[adcRoute] : junk;
   assign outReady = !stall && (slow != 2'h3);
endmodule

// *** tb/orps_top_bench.sv ***
/*
 Self-checking bench for orps_top: reset values, analog settings and one
 full period of conversions with a stalled sink, then result readback.
 Assumes orps_far_end and the bound checker are compiled alongside.
*/
`timescale 1ns/100ps
module orps_top_bench import orps_pkg::*;;
   localparam int DW = 22;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [5:0] regAddr = 6'h00;
   logic [31:0] regWdata = 32'h0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic stall = 1'b0;
   logic [3:0][DW-1:0] codes = {22'h2abcde, 22'h3f0f0f, 22'h012345, 22'h0a5a5a};
   logic [31:0] regRdata;
   logic [DW-1:0] adcCode;
   logic [1:0] adcRoute;
   logic adcBusy, workTick, outValid, outReady;
   logic emitterBSamplePhase, emitterASamplePhase, ambientBSamplePhase, ambientASamplePhase;
   logic emitterBConvertPhase, emitterAConvertPhase, ambientBConvertPhase, ambientAConvertPhase;
   logic [2:0] gainSel, feedbackRSel;
   logic [5:0] feedbackCMask;
   logic [3:0] ambientDac;
   logic [DW+3:0] outData;
   int bad_count = 0;
   int check_count = 0;
   int gotCnt [8];
   logic [22:0] gotVal [8];

   orps_top #(.DATA_W(DW)) u_dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .adcCode(adcCode), .adcRoute(adcRoute), .adcBusy(adcBusy),
      .emitterBSamplePhase(emitterBSamplePhase), .emitterASamplePhase(emitterASamplePhase),
      .ambientBSamplePhase(ambientBSamplePhase), .ambientASamplePhase(ambientASamplePhase),
      .emitterBConvertPhase(emitterBConvertPhase), .emitterAConvertPhase(emitterAConvertPhase),
      .ambientBConvertPhase(ambientBConvertPhase), .ambientAConvertPhase(ambientAConvertPhase),
      .gainSel(gainSel), .feedbackRSel(feedbackRSel), .feedbackCMask(feedbackCMask),
      .ambientDac(ambientDac), .workTick(workTick), .outData(outData), .outValid(outValid),
      .outReady(outReady));
   orps_far_end #(.DATA_W(DW)) u_far (.clk(clk), .rst_n(rst_n), .adcRoute(adcRoute),
      .adcBusy(adcBusy), .stall(stall), .codeSet(codes), .adcCode(adcCode),
      .outReady(outReady));

   always #10 clk = ~clk;

   always @(posedge clk) begin
      if (outValid === 1'b1 && outReady === 1'b1) begin
         gotCnt[outData[DW+3:DW+1]]++;
         gotVal[outData[DW+3:DW+1]] = outData[DW:0];
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask

   task automatic rd(input logic [5:0] a, output logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask

   task automatic finish_test();
      if (bad_count == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic test_reset_values();
      logic [31:0] d;
      rd(OFS_PERIOD, d);
      chk("period reset", {16'h0, PERIOD_RST}, d);
      rd(6'h3f, d);
      chk("unmapped read", 32'h0, d);
      chk("gain reset", {29'h0, GAIN_RST}, {29'h0, gainSel});
      chk("dac reset", {28'h0, DAC_RST}, {28'h0, ambientDac});
   endtask

   task automatic test_settings();
      for (int i = 0; i <= 5; i++) begin
         wr(OFS_GAIN, 32'(i));
         #1 chk("gainSel", 32'(i < 5 ? i : 4), {29'h0, gainSel});
      end
      for (int i = 0; i <= 7; i++) begin
         wr(OFS_RF, 32'(i));
         #1 chk("feedbackRSel", 32'(i < 7 ? i : 6), {29'h0, feedbackRSel});
      end
      for (int i = 0; i <= 11; i++) begin
         wr(OFS_DAC, 32'(i));
         #1 chk("ambientDac", 32'(i < 11 ? i : 10), {28'h0, ambientDac});
      end
      wr(OFS_CF, 32'h29);
      #1 chk("feedbackCMask", 32'h29, {26'h0, feedbackCMask});
      wr(OFS_CF, 32'h3f);
      #1 chk("feedbackCMask", 32'h3f, {26'h0, feedbackCMask});
   endtask

   task automatic test_period();
      logic [31:0] d;
      logic [22:0] e [6];
      logic [1:0] q;
      int n;
      for (int ch = 0; ch < 4; ch++) begin
         q = {ch[0], ch[1]};
         wr(OFS_SAMP_BASE + 6'(2 * ch), 32'(2'(q + 2'h3) * 256 + 5));
         wr(OFS_SAMP_BASE + 6'(2 * ch + 1), 32'(2'(q + 2'h3) * 256 + 220));
         wr(OFS_CONV_BASE + 6'(2 * ch), 32'(q * 256 + 2));
         wr(OFS_CONV_BASE + 6'(2 * ch + 1), 32'(q * 256 + 250));
      end
      // Emitter B window ends early and must be stretched to the least length
      wr(OFS_SAMP_BASE + 6'h01, 32'h0320);
      wr(OFS_PERIOD, 32'h3ff);
      wr(OFS_CTRL, 32'h1);
      // First emitter B window has nothing held, so the wait spans a period
      n = 0;
      while (emitterBConvertPhase !== 1'b1 && n < 40000) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("emB convert start", 32'h1, {31'h0, emitterBConvertPhase});
      for (int t = 0; t < 8; t++) gotCnt[t] = 0;
      @(posedge clk);
      stall <= 1'b1;
      repeat (9600) @(posedge clk);
      chk("held words", 32'h1, {31'h0, outValid});
      stall <= 1'b0;
      repeat (4600) @(posedge clk);
      for (int t = 0; t < 4; t++) e[t] = {codes[t][DW-1], codes[t]};
      e[4] = e[0] - e[2];
      e[5] = e[1] - e[3];
      for (int t = 0; t < 6; t++) begin
         chk("words per tag", 32'h1, 32'(gotCnt[t]));
         chk("stream value", {9'h0, e[t]}, {9'h0, gotVal[t]});
         rd(OFS_RES_BASE + 6'(t), d);
         chk("result register", {{9{e[t][22]}}, e[t]}, d);
      end
      rd(OFS_STATUS, d);
      chk("overrun flag", 32'h0, {31'h0, d[ST_OVERRUN]});
      chk("collide flag", 32'h0, {31'h0, d[ST_COLLIDE]});
      rd(OFS_COUNT, d);
      chk("counter below period", 32'h1, {31'h0, d < 32'h400});
   endtask

   initial begin
      #1600000;
      bad_count++;
      finish_test();
   end

   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      test_reset_values();
      test_settings();
      test_period();
      finish_test();
   end
endmodule
